/* rtl/dcs_top.sv */
// Purpose: capability bytes, soft control/status byte and its timing on the two-wire bus
// Assumes: scl/sda pins sampled on link_clk_i, which runs far faster than the bus clock
// Notes:   register access lives on the link clock, timers and pin logic on clock_i
//
// Overview of operation
// - diag-type bit 7 reads zero
// - diag-type bit 6 reads one
// - bits 5/4 give internal or external calibration
// - bit 3: zero modulation, one average power
// - bit 2 address-change flag; bits 1-0 reserved
// - enhanced bits 7-3 show implemented features
// - rate and disable bits always read/write
// - soft disable drops output within 100 ms
// - soft enable restores output within 100 ms
// - init within 300 ms, also after fault reset
// - fault status set within 100 ms
// - loss flag follows loss state within 100 ms
// - rate change effective within 100 ms
// - data-ready bit set within 1000 ms
// - soft timing counted from stop of write
// - host sets and polls soft states serially
// - both device addresses reached directly
`timescale 1ns/1ps
`default_nettype none
module dcs_top
  import dcs_pkg::*;
#(
  parameter logic [DCS_CNT_W-1:0] INIT_CYCLES = DCS_CNT_W'(DCS_INIT_CYC),
  parameter logic [DCS_CNT_W-1:0] DATA_CYCLES = DCS_CNT_W'(DCS_DATA_CYC)
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic link_clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic tx_fault_i,
  input  wire logic signal_loss_state_i,
  output logic      tx_output_enable_o,
  output logic      rate_select_o,
  output logic      serial_ready_o
);

  // ---------------- link domain ----------------
  logic [1:0]      pin_s;
  logic            scl_s;
  logic            sda_s;
  logic            scl_d_reg;
  logic            sda_d_reg;
  logic            scl_rise;
  logic            scl_fall;
  logic            bus_start;
  logic            bus_stop;
  logic [3:0]      stat_s;
  logic            ready_l;
  logic            fault_l;
  logic            loss_l;
  logic            data_l;
  dcs_link_state_t state_reg;
  logic [3:0]      cnt_reg;
  logic [7:0]      shift_reg;
  logic [7:0]      tx_byte_reg;
  logic [7:0]      ptr_reg;
  logic            diag_sel_reg;
  logic            rw_reg;
  logic            ctrl_txdis_reg;
  logic            ctrl_rate_reg;
  logic            pend_txdis_reg;
  logic            pend_rate_reg;
  logic            pend_reg;
  logic [7:0]      rd_byte;
  logic            addr_hit;
  logic            wr_hit;

  // ---------------- core domain ----------------
  logic [3:0]            core_s;
  logic                  txdis_s;
  logic                  rate_s;
  logic                  fault_s;
  logic                  loss_s;
  logic                  txdis_eff;
  logic                  txdis_d_reg;
  logic                  txdis_rise;
  logic                  txdis_fall;
  logic [DCS_CNT_W-1:0]  init_cnt_reg;
  logic                  init_busy_reg;
  logic                  por_done_reg;
  logic                  recover_reg;
  logic [DCS_CNT_W-1:0]  data_cnt_reg;
  logic                  data_ready_reg;
  logic                  fault_reg;
  logic                  loss_reg;

  // bus pins are asynchronous to the link clock; carried inverted so the
  // synchroniser's zero reset equals the released (high) bus, no false edge
  dcs_sync #(.W(2)) u_pin_sync (
    .clk_i (link_clk_i),
    .rst_i (rst_i),
    .d_i   ({~scl_i, ~sda_i}),
    .q_o   (pin_s)
  );

  // status levels from the core, each bit independent
  dcs_sync #(.W(4)) u_stat_sync (
    .clk_i (link_clk_i),
    .rst_i (rst_i),
    .d_i   ({por_done_reg, fault_reg, loss_reg, data_ready_reg}),
    .q_o   (stat_s)
  );

  // control levels and analog pins into the core clock
  dcs_sync #(.W(4)) u_core_sync (
    .clk_i (clock_i),
    .rst_i (rst_i),
    .d_i   ({ctrl_txdis_reg, ctrl_rate_reg, tx_fault_i, signal_loss_state_i}),
    .q_o   (core_s)
  );

  assign scl_s   = ~pin_s[1];
  assign sda_s   = ~pin_s[0];
  assign ready_l = stat_s[3];
  assign fault_l = stat_s[2];
  assign loss_l  = stat_s[1];
  assign data_l  = stat_s[0];

  // delayed copies for edge and condition detection
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  assign addr_hit = ready_l & ((shift_reg[7:1] == DCS_ADDR_ID) |
                               (shift_reg[7:1] == DCS_ADDR_DIAG));

  // read data mux; anything unmapped reads zero
  always_comb begin
    rd_byte = 8'h00;
    if (!diag_sel_reg) begin
      if (ptr_reg == DCS_OFS_DIAG_TYPE) begin
        rd_byte = DCS_DIAG_TYPE_VAL;
      end
      if (ptr_reg == DCS_OFS_ENHANCED) begin
        rd_byte = DCS_ENHANCED_VAL;
      end
    end else if (ptr_reg == DCS_OFS_CTRL) begin
      rd_byte[DCS_BIT_TXDIS] = ctrl_txdis_reg;
      rd_byte[DCS_BIT_RATE]  = ctrl_rate_reg;
      rd_byte[DCS_BIT_FAULT] = fault_l;
      rd_byte[DCS_BIT_LOSS]  = loss_l;
      rd_byte[DCS_BIT_READY] = data_l;
    end
  end

  // only the control byte is ever written
  assign wr_hit = scl_fall & (state_reg == DCS_S_WDAT) & (cnt_reg == DCS_BYTE_BITS) &
                  diag_sel_reg & (ptr_reg == DCS_OFS_CTRL);

  // two-wire slave protocol; sda is only ever pulled low
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= DCS_S_IDLE;
      cnt_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      tx_byte_reg  <= 8'h00;
      ptr_reg      <= 8'h00;
      diag_sel_reg <= 1'b0;
      rw_reg       <= 1'b0;
      sda_oe_o     <= 1'b0;
    end else if (bus_start) begin
      state_reg <= DCS_S_ADDR;
      cnt_reg   <= 4'h0;
      sda_oe_o  <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= DCS_S_IDLE;
      sda_oe_o  <= 1'b0;
    end else if (scl_rise) begin
      if ((state_reg == DCS_S_ADDR) || (state_reg == DCS_S_WOFF) ||
          (state_reg == DCS_S_WDAT)) begin
        shift_reg <= {shift_reg[6:0], sda_s};
        cnt_reg   <= cnt_reg + 4'h1;
      end else if ((state_reg == DCS_S_RACK) && sda_s) begin
        state_reg <= DCS_S_IDLE; // master nack ends the read
      end
    end else if (scl_fall) begin
      unique case (state_reg)
        DCS_S_IDLE: begin
          sda_oe_o <= 1'b0;
        end
        DCS_S_ADDR: begin
          if (cnt_reg == DCS_BYTE_BITS) begin
            if (addr_hit) begin
              diag_sel_reg <= (shift_reg[7:1] == DCS_ADDR_DIAG);
              rw_reg       <= shift_reg[0];
              sda_oe_o     <= 1'b1;
              state_reg    <= DCS_S_AACK;
            end else begin
              state_reg <= DCS_S_IDLE;
            end
          end
        end
        DCS_S_AACK, DCS_S_RACK: begin
          if (rw_reg) begin
            tx_byte_reg <= {rd_byte[6:0], 1'b0};
            sda_oe_o    <= ~rd_byte[7];
            cnt_reg     <= 4'h1;
            ptr_reg     <= ptr_reg + 8'h01;
            state_reg   <= DCS_S_RD;
          end else begin
            sda_oe_o  <= 1'b0;
            cnt_reg   <= 4'h0;
            state_reg <= DCS_S_WOFF;
          end
        end
        DCS_S_WOFF: begin
          if (cnt_reg == DCS_BYTE_BITS) begin
            ptr_reg   <= shift_reg;
            sda_oe_o  <= 1'b1;
            state_reg <= DCS_S_OACK;
          end
        end
        DCS_S_OACK, DCS_S_DACK: begin
          sda_oe_o  <= 1'b0;
          cnt_reg   <= 4'h0;
          state_reg <= DCS_S_WDAT;
        end
        DCS_S_WDAT: begin
          if (cnt_reg == DCS_BYTE_BITS) begin
            ptr_reg   <= ptr_reg + 8'h01;
            sda_oe_o  <= 1'b1;
            state_reg <= DCS_S_DACK;
          end
        end
        DCS_S_RD: begin
          if (cnt_reg == DCS_BYTE_BITS) begin
            sda_oe_o  <= 1'b0;
            state_reg <= DCS_S_RACK;
          end else begin
            sda_oe_o    <= ~tx_byte_reg[7];
            tx_byte_reg <= {tx_byte_reg[6:0], 1'b0};
            cnt_reg     <= cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // open-drain data: the driven level is always low
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // soft control bits, staged until the write ends
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_txdis_reg <= 1'b0;
      ctrl_rate_reg  <= 1'b0;
      pend_txdis_reg <= 1'b0;
      pend_rate_reg  <= 1'b0;
      pend_reg       <= 1'b0;
    end else if (wr_hit) begin
      // stored even when the feature is absent
      pend_txdis_reg <= shift_reg[DCS_BIT_TXDIS];
      pend_rate_reg  <= shift_reg[DCS_BIT_RATE];
      pend_reg       <= 1'b1;
    end else if (bus_stop && pend_reg) begin
      // apply at stop, ahead of the reference edge
      ctrl_txdis_reg <= pend_txdis_reg;
      ctrl_rate_reg  <= pend_rate_reg;
      pend_reg       <= 1'b0;
    end
  end

  // ---------------- core domain logic ----------------
  assign txdis_s = core_s[3];
  assign rate_s  = core_s[2];
  assign fault_s = core_s[1];
  assign loss_s  = core_s[0];

  // absent feature ignores the stored bit
  assign txdis_eff  = txdis_s & DCS_FEAT_TXDIS;
  assign txdis_rise = txdis_eff & ~txdis_d_reg;
  assign txdis_fall = ~txdis_eff & txdis_d_reg;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      txdis_d_reg <= 1'b0;
    end else begin
      txdis_d_reg <= txdis_eff;
    end
  end

  // init timer, rerun on fault recovery
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      init_cnt_reg  <= '0;
      init_busy_reg <= 1'b1;
      por_done_reg  <= 1'b0;
    end else if (txdis_fall && recover_reg) begin
      init_cnt_reg  <= '0;
      init_busy_reg <= 1'b1;
    end else if (init_busy_reg) begin
      if (init_cnt_reg == INIT_CYCLES - DCS_CNT_ONE) begin
        init_busy_reg <= 1'b0;
        por_done_reg  <= 1'b1; // serial access opens here, sticky
      end else begin
        init_cnt_reg <= init_cnt_reg + DCS_CNT_ONE;
      end
    end
  end

  // analog data valid after its own timer
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      data_cnt_reg   <= '0;
      data_ready_reg <= 1'b0;
    end else if (!data_ready_reg) begin
      if (data_cnt_reg == DATA_CYCLES - DCS_CNT_ONE) begin
        data_ready_reg <= 1'b1;
      end else begin
        data_cnt_reg <= data_cnt_reg + DCS_CNT_ONE;
      end
    end
  end

  // sticky fault, set beats the disable clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fault_reg   <= 1'b0;
      recover_reg <= 1'b0;
    end else begin
      if (fault_s && DCS_FEAT_FAULT) begin
        fault_reg <= 1'b1;
      end else if (txdis_rise) begin
        fault_reg <= 1'b0;
      end
      if (txdis_rise && fault_reg) begin
        recover_reg <= 1'b1;
      end else if (txdis_fall) begin
        recover_reg <= 1'b0;
      end
    end
  end

  // loss flag tracks the state both ways
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      loss_reg <= 1'b0;
    end else begin
      loss_reg <= loss_s & DCS_FEAT_LOSS;
    end
  end

  // laser gate, a few cycles after the sync
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_output_enable_o <= 1'b0;
    end else begin
      tx_output_enable_o <= ~txdis_eff & ~fault_reg & ~init_busy_reg;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rate_select_o <= 1'b0;
    end else begin
      rate_select_o <= rate_s & DCS_FEAT_RATE;
    end
  end

  // power-on init done, visible to the system
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      serial_ready_o <= 1'b0;
    end else begin
      serial_ready_o <= por_done_reg;
    end
  end

endmodule
`default_nettype wire

/* rtl/dcs_pkg.sv */
// Purpose: shared constants and types for the diagnostic capability and soft control block
// Assumes: 125 MHz core clock, byte-wide two-wire register space
// Notes:   capability values are built from the feature switches below
package dcs_pkg;

  // two-wire device identities (7-bit form of the 8-bit addresses)
  localparam logic [6:0] DCS_ADDR_ID   = 7'h50;
  localparam logic [6:0] DCS_ADDR_DIAG = 7'h51;

  // byte offsets
  localparam logic [7:0] DCS_OFS_DIAG_TYPE = 8'h5c;
  localparam logic [7:0] DCS_OFS_ENHANCED  = 8'h5d;
  localparam logic [7:0] DCS_OFS_CTRL      = 8'h6e;

  // control/status byte bit positions
  localparam int DCS_BIT_TXDIS = 6;
  localparam int DCS_BIT_RATE  = 3;
  localparam int DCS_BIT_FAULT = 2;
  localparam int DCS_BIT_LOSS  = 1;
  localparam int DCS_BIT_READY = 0;

  // implementation switches
  localparam logic DCS_CAL_INTERNAL   = 1'b1;
  localparam logic DCS_AVG_POWER      = 1'b1;
  localparam logic DCS_ADDR_CHANGE    = 1'b0;
  localparam logic DCS_FEAT_ALARMS    = 1'b0;
  localparam logic DCS_FEAT_TXDIS     = 1'b1;
  localparam logic DCS_FEAT_FAULT     = 1'b1;
  localparam logic DCS_FEAT_LOSS      = 1'b1;
  localparam logic DCS_FEAT_RATE      = 1'b1;

  // capability bytes, reserved bits forced to zero
  localparam logic [7:0] DCS_DIAG_TYPE_VAL = {1'b0, 1'b1, DCS_CAL_INTERNAL, ~DCS_CAL_INTERNAL,
                                              DCS_AVG_POWER, DCS_ADDR_CHANGE, 2'h0};
  localparam logic [7:0] DCS_ENHANCED_VAL  = {DCS_FEAT_ALARMS, DCS_FEAT_TXDIS, DCS_FEAT_FAULT,
                                              DCS_FEAT_LOSS, DCS_FEAT_RATE, 3'h0};

  // timing
  localparam int DCS_CLK_HZ    = 125_000_000;
  localparam int DCS_T_INIT_MS = 300;
  localparam int DCS_T_DATA_MS = 1000;
  localparam int DCS_INIT_CYC  = DCS_T_INIT_MS * (DCS_CLK_HZ / 1000);
  localparam int DCS_DATA_CYC  = DCS_T_DATA_MS * (DCS_CLK_HZ / 1000);
  localparam int DCS_CNT_W     = 27;
  localparam logic [DCS_CNT_W-1:0] DCS_CNT_ONE = 27'h1;

  localparam logic [3:0] DCS_BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    DCS_S_IDLE, DCS_S_ADDR, DCS_S_AACK, DCS_S_WOFF, DCS_S_OACK,
    DCS_S_WDAT, DCS_S_DACK, DCS_S_RD, DCS_S_RACK
  } dcs_link_state_t;

endpackage

/* rtl/dcs_sync.sv */
// Purpose: two-flop level synchroniser, one bit lane per input
// Assumes: inputs are levels that hold for several destination clocks
// Notes:   lanes are independent, so no word coherency is promised
`timescale 1ns/1ps
`default_nettype none
module dcs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule
`default_nettype wire

/* dv/dcs_top_monitor.sv */
// Purpose: port-level checker for the capability and soft control block
// Assumes: bound to dcs_top; one reset serves both clock domains
// Notes:   init timing is counted from reset release on clock_i
`timescale 1ns/1ps
`default_nettype none
module dcs_top_monitor
  import dcs_pkg::*;
#(
  parameter logic [DCS_CNT_W-1:0] INIT_CYCLES = DCS_CNT_W'(DCS_INIT_CYC),
  parameter logic [DCS_CNT_W-1:0] DATA_CYCLES = DCS_CNT_W'(DCS_DATA_CYC)
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic tx_fault_i,
  input wire logic signal_loss_state_i,
  input wire logic tx_output_enable_o,
  input wire logic rate_select_o,
  input wire logic serial_ready_o
);
  logic [DCS_CNT_W-1:0] up_cnt_reg;

  // cycles since reset; saturates so a long run never wraps
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      up_cnt_reg <= '0;
    end else if (!(&up_cnt_reg)) begin
      up_cnt_reg <= up_cnt_reg + DCS_CNT_ONE;
    end
  end

  a_sda_drive_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
    sda_o == 1'b0) else $error("sda drive value not zero");
  a_ack_scl_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $changed(sda_oe_o) |-> !scl_i) else $error("sda enable moved while scl high");
  a_quiet_before_init: assert property (@(posedge clock_i) disable iff (rst_i)
    !serial_ready_o |-> !sda_oe_o) else $error("bus answered before init");
  a_ready_not_early: assert property (@(posedge clock_i) disable iff (rst_i)
    serial_ready_o |-> up_cnt_reg >= INIT_CYCLES) else $error("ready before init time");
  a_ready_in_time: assert property (@(posedge clock_i) disable iff (rst_i)
    up_cnt_reg == INIT_CYCLES + 27'h0c |-> serial_ready_o) else $error("ready late");
  a_ready_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
    serial_ready_o |=> serial_ready_o) else $error("ready dropped");
  a_laser_needs_init: assert property (@(posedge clock_i) disable iff (rst_i)
    tx_output_enable_o |-> serial_ready_o) else $error("laser on before init");
  a_fault_drops_laser: assert property (@(posedge clock_i) disable iff (rst_i)
    tx_fault_i |-> ##[0:10] !tx_output_enable_o) else $error("laser stayed on in fault");
  a_fault_holds_off: assert property (@(posedge clock_i) disable iff (rst_i)
    !tx_output_enable_o && tx_fault_i |=> !tx_output_enable_o) else $error("laser on in fault");
  a_rate_after_stop: assert property (@(posedge clock_i) disable iff (rst_i)
    $changed(rate_select_o) |-> scl_i && sda_i) else $error("rate moved inside a transfer");

  // main scenarios reached
  c_ack: cover property (@(posedge link_clk_i) disable iff (rst_i) $rose(sda_oe_o));
  c_fault: cover property (@(posedge clock_i) disable iff (rst_i) tx_fault_i && !tx_output_enable_o);
  c_rate: cover property (@(posedge clock_i) disable iff (rst_i) $rose(rate_select_o));
endmodule
`default_nettype wire

/* dv/dcs_host_model.sv */
// Purpose: two-wire bus master standing in for the host controller
// Assumes: sda has a pull-up; the device only ever pulls it low
// Notes:   scl held high between frames; one bit takes 10 us
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model (
  input  wire logic dev_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  // quarter bit, 100 kHz bus clock at most
  localparam time QTR = 2500ns;
  logic drv_low;

  // resolved wire: pull-up unless either party pulls low
  assign sda_o = !(drv_low || dev_oe_i);

  // bus released at time zero
  initial begin
    scl_o = 1'b1;
    drv_low = 1'b0;
  end

  // start or repeated start, leaves scl low
  task automatic start();
    drv_low = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR drv_low = 1'b1;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask

  task automatic stop();
    drv_low = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR drv_low = 1'b0;
    #(2*QTR);
  endtask

  // data changes only while scl is low
  task automatic bit_out(input logic b);
    drv_low = !b;
    #QTR scl_o = 1'b1;
    #(2*QTR) scl_o = 1'b0;
    #QTR;
  endtask

  task automatic bit_in(output logic b);
    drv_low = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR b = sda_o;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask

  task automatic tx(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(ack);
    ack = !ack;
  endtask

  task automatic rx(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: self-checking bench for capability bytes and soft control timing
// Assumes: init and data-ready counts shortened to 40 and 100 cycles
// Notes:   each bus bit takes 10 us, so the run is bus bound
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dcs_pkg::*;
;
  localparam logic [DCS_CNT_W-1:0] T_INIT = 27'h28;
  localparam logic [DCS_CNT_W-1:0] T_DATA = 27'h64;
  logic clock_i, rst_i, link_clk_i, tx_fault_i, signal_loss_state_i;
  logic scl, sda, sda_drv, sda_oe, tx_en, rate, ready;
  int   n_fail, tests_run;

  dcs_top #(.INIT_CYCLES(T_INIT), .DATA_CYCLES(T_DATA)) u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_drv), .sda_oe_o(sda_oe), .tx_fault_i(tx_fault_i),
    .signal_loss_state_i(signal_loss_state_i), .tx_output_enable_o(tx_en),
    .rate_select_o(rate), .serial_ready_o(ready));
  dcs_host_model u_host (.dev_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  // 125 MHz core clock, 48 ns link clock with its own phase
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = !clock_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3;
    forever #24 link_clk_i = !link_clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait on the laser enable; a spent bound ends the run
  task automatic wait_en(input logic lvl, input int lim);
    int k;
    k = 0;
    while (tx_en !== lvl && k < lim) begin
      @(posedge clock_i);
      k++;
    end
    if (k >= lim) begin
      n_fail++;
      $display("ERROR laser wait expected %b seen timeout", lvl);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d);
    logic k0, k1, k2;
    u_host.start();
    u_host.tx({a, 1'b0}, k0);
    u_host.tx(off, k1);
    u_host.tx(d, k2);
    u_host.stop();
    chk("write acks", 8'h07, {5'h0, k0, k1, k2});
  endtask

  // random read of two bytes, host nacks the second
  task automatic rd(input logic [6:0] a, input logic [7:0] off, output logic [7:0] b0, b1);
    logic k0, k1, k2;
    u_host.start();
    u_host.tx({a, 1'b0}, k0);
    u_host.tx(off, k1);
    u_host.start();
    u_host.tx({a, 1'b1}, k2);
    u_host.rx(1'b0, b0);
    u_host.rx(1'b1, b1);
    u_host.stop();
    chk("read acks", 8'h07, {5'h0, k0, k1, k2});
  endtask

  task automatic t_caps();
    logic [7:0] b0, b1;
    logic ack;
    rd(DCS_ADDR_ID, DCS_OFS_DIAG_TYPE, b0, b1);
    chk("diag type reserved", 8'h00, b0 & 8'h83);
    chk("diag type", 8'h68, b0);
    chk("enhanced options", 8'h78, b1);
    u_host.start();
    u_host.tx({7'h52, 1'b0}, ack);
    u_host.stop();
    chk("unknown address ack", 8'h00, {7'h0, ack});
    $display("test caps done");
  endtask

  task automatic t_soft_set();
    @(posedge clock_i);
    #1 signal_loss_state_i = 1'b1;
    wr(DCS_ADDR_DIAG, DCS_OFS_CTRL, 8'h4f);
    wait_en(1'b0, 50);
    chk("laser after disable", 8'h00, {7'h0, tx_en});
    repeat (8) @(posedge clock_i);
    chk("rate select set", 8'h01, {7'h0, rate});
    $display("test soft set done");
  endtask

  task automatic t_status();
    logic [7:0] b0, b1;
    rd(DCS_ADDR_DIAG, DCS_OFS_CTRL, b0, b1);
    chk("control byte", 8'h4b, b0);
    chk("byte after control", 8'h00, b1);
    $display("test status done");
  endtask

  task automatic t_soft_clear();
    @(posedge clock_i);
    #1 signal_loss_state_i = 1'b0;
    wr(DCS_ADDR_DIAG, DCS_OFS_CTRL, 8'h00);
    wait_en(1'b1, 100);
    chk("laser after enable", 8'h01, {7'h0, tx_en});
    chk("rate select clear", 8'h00, {7'h0, rate});
    $display("test soft clear done");
  endtask

  // a short fault must leave the laser latched off
  task automatic t_fault();
    @(posedge clock_i);
    #1 tx_fault_i = 1'b1;
    wait_en(1'b0, 20);
    @(posedge clock_i);
    #1 tx_fault_i = 1'b0;
    repeat (20) @(posedge clock_i);
    chk("laser after fault", 8'h00, {7'h0, tx_en});
    $display("test fault done");
  endtask

  // reset held six core clocks, then wait for init
  initial begin
    int k;
    rst_i = 1'b1;
    tx_fault_i = 1'b0;
    signal_loss_state_i = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (6) @(posedge clock_i);
    #1 rst_i = 1'b0;
    chk("laser at reset", 8'h00, {7'h0, tx_en});
    for (k = 0; k < 200 && ready !== 1'b1; k++) @(posedge clock_i);
    if (k >= 200) begin
      n_fail++;
      $display("ERROR ready expected 1 seen timeout");
      print_verdict();
    end
    repeat (10) @(posedge link_clk_i);
    chk("laser after init", 8'h01, {7'h0, tx_en});
    t_caps();
    t_soft_set();
    t_status();
    t_soft_clear();
    t_fault();
    print_verdict();
  end
endmodule

bind dcs_top dcs_top_monitor #(.INIT_CYCLES(INIT_CYCLES), .DATA_CYCLES(DATA_CYCLES)) u_mon (
  .clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .tx_fault_i(tx_fault_i),
  .signal_loss_state_i(signal_loss_state_i), .tx_output_enable_o(tx_output_enable_o),
  .rate_select_o(rate_select_o), .serial_ready_o(serial_ready_o));
`default_nettype wire
